// ### logic/fbx_function_box.sv
// Arithmetic and combinatorial function box with its condition nibbles
// and the four-bit function box.
// Assumes X, Y and the control byte are held in registers elsewhere; the
// sequencer reads these results by register moves within the same cycle.
//
// Contract
// - Unit type 00 binary bits, 01 four-bit digits, 11 eight-bit units, 10 undefined.
// - All results and conditions are pure combinational logic, no start or wait.
// - Sum is X+Y+carry flag, zero above operand length, binary for type 00.
// - Type 01 adds up to six decimal digits, carrying when a digit exceeds 9.
// - Type 11 adds low nibbles decimally with carries; upper nibbles OR the inputs.
// - Difference is X plus complement of Y and carry flag, zero above length.
// - Borrow-out is set when the difference is negative, over all 24 bits.
// - Type 00 difference is binary, negative values in two's complement.
// - Type 01 difference is decimal with digit borrows, negatives in ten's complement.
// - Type 11 difference: low nibbles decimal, upper bits OR, ten's complement.
// - AND, OR and XOR of X and Y, zero above operand length.
// - One's complement of X and of Y, zero above operand length.
// - Masked X and Y keep only the operand length of low bits.
// - Binary nibble: carry-out, borrow-out, carry flag, Y low-unit flag.
// - Y low-unit: bit 0 set for type 00, low nibble 1001 for 01/11.
// - Carry-out comes from the operand's top position under the operand length.
// - Relation nibble: X>Y, X<Y, X=Y, X top bit; full 24-bit compares.
// - X top-bit flag is the bit of X picked by the operand length.
// - State nibble: X nonzero, Y nonzero, any-interrupt, X low-unit flag.
// - Any-interrupt ORs port normal, high, missing, timer, I/O, console, parity, write OOB; not port lockout or read OOB.
// - X low-unit: bit 0 set for type 00, low nibble 1001 for 01/11.
// - Four-bit box: set, AND, OR, XOR, mod-16 sum and difference with flags.
// - Four-bit result goes back only to its source; condition nibbles never written.
// - Port nibble: lockout, normal, high priority, missing device in bits 0..3.
// - Operand length is five bits, at most 24; larger values are reserved.
// - Memory nibble: write OOB, read OOB, override, parity in bits 0..3.
`include "fbx_consts.svh"

module fbx_function_box (
  input  wire fbx_pkg::fbx_ctrl_s    ctrl_i,       // Carry flag, unit type, length
  input  wire logic [23:0]           x_i,          // X operand register
  input  wire logic [23:0]           y_i,          // Y operand register
  input  wire logic [3:0]            proc_status_i,// Processor status nibble
  input  wire logic [3:0]            mem_status_i, // Memory status nibble
  input  wire logic [3:0]            port_lines_i, // Port interchange condition lines
  input  wire fbx_pkg::fbx_nib_req_s nib_req_i,    // Four-bit manipulate request
  output fbx_pkg::fbx_result_s       result_o,     // 24-bit results
  output fbx_pkg::fbx_cond_s         cond_o,       // Condition nibbles
  output fbx_pkg::fbx_nib_ans_s      nib_ans_o     // Four-bit result, write, skip
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [23:0] len_mask(input logic [4:0] len);
    if (len >= `FBX_LEN_MAX) begin
      len_mask = 24'hFF_FFFF;
    end else begin
      len_mask = 24'(25'h000_0001 << len) - 24'h00_0001;
    end
  endfunction

  // Decimal digit add: returns {carry, digit}
  function automatic logic [4:0] dec_add(input logic [3:0] a, input logic [3:0] b,
                                         input logic cin);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    if (s > {1'b0, `FBX_BCD_NINE}) begin
      dec_add = {1'b1, 4'(s - `FBX_BCD_TEN)};
    end else begin
      dec_add = {1'b0, s[3:0]};
    end
  endfunction

  // Decimal digit subtract: returns {borrow, digit}, ten's complement on borrow
  function automatic logic [4:0] dec_sub(input logic [3:0] a, input logic [3:0] b,
                                         input logic bin);
    logic [4:0] need;
    need = {1'b0, b} + {4'h0, bin};
    if ({1'b0, a} < need) begin
      dec_sub = {1'b1, 4'({1'b0, a} + `FBX_BCD_TEN - need)};
    end else begin
      dec_sub = {1'b0, 4'({1'b0, a} - need)};
    end
  endfunction

  function automatic logic low_unit(input logic [1:0] ut, input logic [3:0] v);
    case (ut)
      `FBX_UNIT_BIN:                low_unit = v[0];
      `FBX_UNIT_DEC4, `FBX_UNIT_DEC8: low_unit = (v == `FBX_BCD_NINE);
      default:                      low_unit = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Arithmetic unit
  // ****************************************************************
  // Every path below is combinational so a move into X, Y or the control
  // byte is seen by the very next micro-instruction.
  logic [23:0] mask;
  logic [23:0] xm;
  logic [23:0] ym;
  logic [24:0] bin_sum;
  logic [23:0] bin_dif;
  logic [23:0] d4_sum;
  logic [23:0] d4_dif;
  logic [23:0] d8_sum;
  logic [23:0] d8_dif;
  logic [6:0]  d4_cy;
  logic [6:0]  d4_bw;
  logic [3:0]  d8_cy;
  logic [3:0]  d8_bw;
  logic [4:0]  dig;
  logic [2:0]  d4_idx;
  logic [2:0]  d8_idx;
  logic [4:0]  len;
  logic [23:0] sum_r;
  logic [23:0] dif_r;
  logic        carry_out;
  logic        borrow_out;
  logic        cf;

  always_comb begin
    len    = ctrl_i.operand_length;
    cf     = ctrl_i.carry_flag;
    mask   = len_mask(len);
    xm     = x_i & mask;
    ym     = y_i & mask;
    // Binary path
    bin_sum = {1'b0, xm} + {1'b0, ym} + {24'h00_0000, cf};
    // X + ~Y + ~CF is the same as X - Y - CF modulo 2^24
    bin_dif = (xm + (~ym) + {23'h00_0000, ~cf}) & mask;
    // Four-bit decimal chain
    d4_cy[0] = cf;
    d4_bw[0] = cf;
    d4_sum   = 24'h00_0000;
    d4_dif   = 24'h00_0000;
    for (int i = 0; i < 6; i++) begin
      dig                = dec_add(xm[4*i +: 4], ym[4*i +: 4], d4_cy[i]);
      d4_sum[4*i +: 4]   = dig[3:0];
      d4_cy[i+1]         = dig[4];
      dig                = dec_sub(xm[4*i +: 4], ym[4*i +: 4], d4_bw[i]);
      d4_dif[4*i +: 4]   = dig[3:0];
      d4_bw[i+1]         = dig[4];
    end
    // Eight-bit unit chain: decimal low nibble, OR of upper nibble
    d8_cy[0] = cf;
    d8_bw[0] = cf;
    d8_sum   = 24'h00_0000;
    d8_dif   = 24'h00_0000;
    for (int i = 0; i < 3; i++) begin
      dig                  = dec_add(xm[8*i +: 4], ym[8*i +: 4], d8_cy[i]);
      d8_sum[8*i +: 4]     = dig[3:0];
      d8_cy[i+1]           = dig[4];
      d8_sum[8*i+4 +: 4]   = xm[8*i+4 +: 4] | ym[8*i+4 +: 4];
      dig                  = dec_sub(xm[8*i +: 4], ym[8*i +: 4], d8_bw[i]);
      d8_dif[8*i +: 4]     = dig[3:0];
      d8_bw[i+1]           = dig[4];
      d8_dif[8*i+4 +: 4]   = xm[8*i+4 +: 4] | ym[8*i+4 +: 4];
    end
    // Carry index just above the top unit: the last whole digit for type 01, the last unit the length reaches into for type 11
    d4_idx = (len >= `FBX_LEN_MAX) ? 3'h6 : len[4:2];
    d8_idx = (len >= `FBX_LEN_MAX) ? 3'h3 : 3'((len + 5'h07) >> 3);
    // Result select by unit type
    case (ctrl_i.unit_type)
      `FBX_UNIT_BIN: begin
        sum_r     = bin_sum[23:0] & mask;
        dif_r     = bin_dif;
        carry_out = (len >= `FBX_LEN_MAX) ? bin_sum[24] : bin_sum[len];
      end
      `FBX_UNIT_DEC4: begin
        sum_r     = d4_sum & mask;
        dif_r     = d4_dif & mask;
        carry_out = d4_cy[d4_idx];
      end
      `FBX_UNIT_DEC8: begin
        sum_r     = d8_sum & mask;
        dif_r     = d8_dif & mask;
        carry_out = d8_cy[d8_idx[1:0]];
      end
      default: begin
        sum_r     = 24'h00_0000;
        dif_r     = 24'h00_0000;
        carry_out = 1'b0;
      end
    endcase
    // Sign of the full 24-bit difference, independent of the length
    borrow_out = ({1'b0, x_i} < ({1'b0, y_i} + {24'h00_0000, cf}));
  end

  // ****************************************************************
  // Conditions and 24-bit results
  // ****************************************************************
  logic any_int;
  logic x_top;

  always_comb begin
    // Read out-of-bounds and the override deliberately stay out
    any_int = port_lines_i[`FBX_PI_MISSING] | port_lines_i[`FBX_PI_NORMAL] |
              port_lines_i[`FBX_PI_HIGH]    | proc_status_i[`FBX_PS_TIMER] |
              proc_status_i[`FBX_PS_IO]     | proc_status_i[`FBX_PS_CONSOLE] |
              mem_status_i[`FBX_MS_PARITY]  | mem_status_i[`FBX_MS_WR_OOB];
    // Length 0 or reserved lengths select no bit
    if (len == 5'h00 || len > `FBX_LEN_MAX) begin
      x_top = 1'b0;
    end else begin
      x_top = x_i[len - 5'h01];
    end

    result_o.sum_result        = sum_r;
    result_o.difference_result = dif_r;
    result_o.and_result        = (x_i & y_i) & mask;
    result_o.or_result         = (x_i | y_i) & mask;
    result_o.xor_result        = (x_i ^ y_i) & mask;
    result_o.x_complement      = (~x_i) & mask;
    result_o.y_complement      = (~y_i) & mask;
    result_o.x_masked          = xm;
    result_o.y_masked          = ym;

    cond_o.binary_condition_nibble[`FBX_BIC_CARRY]  = carry_out;
    cond_o.binary_condition_nibble[`FBX_BIC_BORROW] = borrow_out;
    cond_o.binary_condition_nibble[`FBX_BIC_CFLAG]  = cf;
    cond_o.binary_condition_nibble[`FBX_BIC_YLOW]   =
      low_unit(ctrl_i.unit_type, y_i[3:0]);

    cond_o.xy_relation_nibble[`FBX_REL_GT]   = (x_i > y_i);
    cond_o.xy_relation_nibble[`FBX_REL_LT]   = (x_i < y_i);
    cond_o.xy_relation_nibble[`FBX_REL_EQ]   = (x_i == y_i);
    cond_o.xy_relation_nibble[`FBX_REL_XTOP] = x_top;

    cond_o.xy_state_nibble[`FBX_ST_XNZ]  = |x_i;
    cond_o.xy_state_nibble[`FBX_ST_YNZ]  = |y_i;
    cond_o.xy_state_nibble[`FBX_ST_INT]  = any_int;
    cond_o.xy_state_nibble[`FBX_ST_XLOW] =
      low_unit(ctrl_i.unit_type, x_i[3:0]);

    cond_o.port_interrupt_nibble = port_lines_i;
  end

  // ****************************************************************
  // Four-bit function box
  // ****************************************************************
  logic [4:0] nsum;
  logic [4:0] ndif;

  always_comb begin
    nsum = {1'b0, nib_req_i.operand} + {1'b0, nib_req_i.literal};
    ndif = {1'b0, nib_req_i.operand} - {1'b0, nib_req_i.literal};
    nib_ans_o.skip = 1'b0;
    case (nib_req_i.variant)
      `FBX_NV_SET: nib_ans_o.result = nib_req_i.literal;
      `FBX_NV_AND: nib_ans_o.result = nib_req_i.operand & nib_req_i.literal;
      `FBX_NV_OR:  nib_ans_o.result = nib_req_i.operand | nib_req_i.literal;
      `FBX_NV_XOR: nib_ans_o.result = nib_req_i.operand ^ nib_req_i.literal;
      `FBX_NV_ADD: nib_ans_o.result = nsum[3:0];
      `FBX_NV_SUB: nib_ans_o.result = ndif[3:0];
      `FBX_NV_ADD_SKIP: begin
        nib_ans_o.result = nsum[3:0];
        nib_ans_o.skip   = nsum[4];
      end
      `FBX_NV_SUB_SKIP: begin
        nib_ans_o.result = ndif[3:0];
        nib_ans_o.skip   = ndif[4];
      end
      default: nib_ans_o.result = nib_req_i.operand;
    endcase
    // Result may only return to its own source, and source-only
    // registers such as the condition nibbles are never written.
    nib_ans_o.write = ~nib_req_i.source_only;
  end

endmodule // fbx_function_box

// ### common/fbx_consts.svh
// Constants for the 24-bit function box: unit codes, field positions, limits.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FBX_CONSTS_SVH
`define FBX_CONSTS_SVH

// ****************************************************************
// Unit type codes
// ****************************************************************
`define FBX_UNIT_BIN      2'h0
`define FBX_UNIT_DEC4     2'h1
`define FBX_UNIT_UNDEF    2'h2
`define FBX_UNIT_DEC8     2'h3

// ****************************************************************
// Widths and limits
// ****************************************************************
`define FBX_WIDTH         24
`define FBX_LEN_MAX       5'h18
`define FBX_BCD_NINE      4'h9
`define FBX_BCD_TEN       5'h0A

// ****************************************************************
// Bit positions inside the condition nibbles
// ****************************************************************
`define FBX_BIC_CARRY     0
`define FBX_BIC_BORROW    1
`define FBX_BIC_CFLAG     2
`define FBX_BIC_YLOW      3
`define FBX_REL_GT        0
`define FBX_REL_LT        1
`define FBX_REL_EQ        2
`define FBX_REL_XTOP      3
`define FBX_ST_XNZ        0
`define FBX_ST_YNZ        1
`define FBX_ST_INT        2
`define FBX_ST_XLOW       3
`define FBX_PI_LOCKOUT    0
`define FBX_PI_NORMAL     1
`define FBX_PI_HIGH       2
`define FBX_PI_MISSING    3
`define FBX_MS_WR_OOB     0
`define FBX_MS_RD_OOB     1
`define FBX_MS_OVERRIDE   2
`define FBX_MS_PARITY     3
`define FBX_PS_CONSOLE    0
`define FBX_PS_IO         1
`define FBX_PS_TIMER      2

// ****************************************************************
// Four-bit manipulate variants
// ****************************************************************
`define FBX_NV_SET        3'h0
`define FBX_NV_AND        3'h1
`define FBX_NV_OR         3'h2
`define FBX_NV_XOR        3'h3
`define FBX_NV_ADD        3'h4
`define FBX_NV_SUB        3'h5
`define FBX_NV_ADD_SKIP   3'h6
`define FBX_NV_SUB_SKIP   3'h7

`endif

// ### common/fbx_pkg.sv
// Types shared by the function box and its neighbours.
// Assumes fbx_consts.svh is on the include path.
`include "fbx_consts.svh"

package fbx_pkg;

  // Low byte of the control register: carry flag, unit type, operand length
  typedef struct packed {
    logic       carry_flag;
    logic [1:0] unit_type;
    logic [4:0] operand_length;
  } fbx_ctrl_s;

  typedef struct packed {
    logic [23:0] sum_result;
    logic [23:0] difference_result;
    logic [23:0] and_result;
    logic [23:0] or_result;
    logic [23:0] xor_result;
    logic [23:0] x_complement;
    logic [23:0] y_complement;
    logic [23:0] x_masked;
    logic [23:0] y_masked;
  } fbx_result_s;

  typedef struct packed {
    logic [3:0] binary_condition_nibble;
    logic [3:0] xy_relation_nibble;
    logic [3:0] xy_state_nibble;
    logic [3:0] port_interrupt_nibble;
  } fbx_cond_s;

  typedef struct packed {
    logic [3:0] operand;
    logic [3:0] literal;
    logic [2:0] variant;
    logic       source_only;
  } fbx_nib_req_s;

  typedef struct packed {
    logic [3:0] result;
    logic       write;
    logic       skip;
  } fbx_nib_ans_s;

endpackage

// ### dv/fbx_function_box_sva.sv
// Checker for the function box: result and condition relations per cycle.
// Assumes the bench clock and reset reach it through the bind below.
module fbx_function_box_chk (
  input wire logic                 mclk_i,        // Bench clock
  input wire logic                 resetn_i,      // Bench reset, active low
  input wire fbx_pkg::fbx_ctrl_s   ctrl_i,        // Control byte
  input wire logic [23:0]          x_i,           // X operand
  input wire logic [23:0]          y_i,           // Y operand
  input wire logic [3:0]           proc_status_i, // Processor status
  input wire logic [3:0]           mem_status_i,  // Memory status
  input wire logic [3:0]           port_lines_i,  // Port lines
  input wire fbx_pkg::fbx_nib_req_s nib_req_i,    // Four-bit request
  input wire fbx_pkg::fbx_result_s result_o,      // Results
  input wire fbx_pkg::fbx_cond_s   cond_o,        // Condition nibbles
  input wire fbx_pkg::fbx_nib_ans_s nib_ans_o     // Four-bit answer
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Reference helpers
  // ****************************************************************
  logic [4:0]  len;
  logic [23:0] mask;
  logic [24:0] bsum;
  logic        top;
  logic        xlow;
  logic        ylow;
  logic        any_int;
  always_comb begin
    len  = ctrl_i.operand_length;
    mask = (len >= 5'h18) ? 24'hFF_FFFF : ((24'h00_0001 << len) - 24'h00_0001);
    bsum = {1'b0, x_i & mask} + {1'b0, y_i & mask} + {24'h00_0000, ctrl_i.carry_flag};
    top  = (len == 5'h00 || len > 5'h18) ? 1'b0 : x_i[len - 5'h01];
    xlow = (ctrl_i.unit_type == 2'h0) ? x_i[0] :
           (ctrl_i.unit_type == 2'h2) ? 1'b0 : (x_i[3:0] == 4'h9);
    ylow = (ctrl_i.unit_type == 2'h0) ? y_i[0] :
           (ctrl_i.unit_type == 2'h2) ? 1'b0 : (y_i[3:0] == 4'h9);
    any_int = |{port_lines_i[3:1], mem_status_i[3], mem_status_i[0], proc_status_i[2:0]};
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  and_masked_a: assert property (result_o.and_result == (x_i & y_i & mask))
    else $error("and result wrong");
  orx_masked_a: assert property (
      result_o.or_result == ((x_i | y_i) & mask) &&
      result_o.xor_result == ((x_i ^ y_i) & mask))
    else $error("or or xor result wrong");
  compl_masked_a: assert property (
      result_o.x_complement == (~x_i & mask) &&
      result_o.y_complement == (~y_i & mask))
    else $error("complement result wrong");
  mask_keep_a: assert property (
      result_o.x_masked == (x_i & mask) && result_o.y_masked == (y_i & mask))
    else $error("masked result wrong");
  bin_sum_a: assert property (
      ctrl_i.unit_type == 2'h0 |-> result_o.sum_result == (bsum[23:0] & mask))
    else $error("binary sum wrong");
  bin_difference_result_a: assert property (
      ctrl_i.unit_type == 2'h0 |-> result_o.difference_result ==
        ((x_i + ~y_i + {23'h00_0000, ~ctrl_i.carry_flag}) & mask))
    else $error("binary difference wrong");
  bin_carry_a: assert property (
      ctrl_i.unit_type == 2'h0 && len != 5'h00 && len <= 5'h18 |->
        cond_o.binary_condition_nibble[0] == bsum[len])
    else $error("carry out wrong");
  bic_flags_a: assert property (
      cond_o.binary_condition_nibble[3:1] == {ylow, ctrl_i.carry_flag,
        ({1'b0, x_i} < ({1'b0, y_i} + {24'h00_0000, ctrl_i.carry_flag}))})
    else $error("binary nibble wrong");
  rel_cmp_a: assert property (
      cond_o.xy_relation_nibble == {top, x_i == y_i, x_i < y_i, x_i > y_i})
    else $error("relation nibble wrong");
  state_bits_a: assert property (
      cond_o.xy_state_nibble == {xlow, any_int, |y_i, |x_i})
    else $error("state nibble wrong");
  port_copy_a: assert property (cond_o.port_interrupt_nibble == port_lines_i)
    else $error("port nibble wrong");
  undef_zero_a: assert property (
      ctrl_i.unit_type == 2'h2 |-> result_o.sum_result == 24'h00_0000 &&
        result_o.difference_result == 24'h00_0000 &&
        cond_o.binary_condition_nibble[0] == 1'b0)
    else $error("undefined type not zero");
  nib_write_a: assert property (nib_ans_o.write == !nib_req_i.source_only)
    else $error("four-bit write wrong");
  settle_a: assert property (
      $stable(x_i) && $stable(y_i) && $stable(ctrl_i) |-> $stable(result_o))
    else $error("results moved without input change");
  cover property (ctrl_i.unit_type == 2'h3 && len == 5'h18);
  cover property (cond_o.binary_condition_nibble[0]);
  cover property (cond_o.xy_state_nibble[2]);
endmodule // fbx_function_box_chk

// The box has no clock, so the checker sits beside it in the bench and
// watches the nets that are wired to the box's ports.
bind fbx_function_box_tb_top fbx_function_box_chk fbx_function_box_chk_inst (
  .mclk_i(mclk_i), .resetn_i(resetn_i),
  .ctrl_i(cq), .x_i(xq), .y_i(yq), .proc_status_i(proc_st),
  .mem_status_i(mem_st), .port_lines_i(port_ln), .nib_req_i(nreq),
  .result_o(res), .cond_o(cnd), .nib_ans_o(nans));

// ### dv/fbx_seq_model.sv
// Sequencer side: holds X, Y and the control byte, loaded by register moves.
// Assumes one clock; condition nibbles are never among its destinations.
module fbx_seq_model (
  input  wire logic               mclk_i,   // Clock
  input  wire logic               resetn_i, // Synchronous reset, active low
  input  wire logic               load_i,   // Register move strobe
  input  wire logic [23:0]        x_d_i,    // New X
  input  wire logic [23:0]        y_d_i,    // New Y
  input  wire fbx_pkg::fbx_ctrl_s ctrl_d_i, // New control byte
  output logic [23:0]             x_o,      // X register
  output logic [23:0]             y_o,      // Y register
  output fbx_pkg::fbx_ctrl_s      ctrl_o    // Control register
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [23:0]        x;
    logic [23:0]        y;
    fbx_pkg::fbx_ctrl_s ctrl;
  } fbx_seq_state_s;
  fbx_seq_state_s st;
  fbx_seq_state_s next_st;
  // Only operand and control registers are writable here
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st = '{x: x_d_i, y: y_d_i, ctrl: ctrl_d_i};
    end
  end
  always_ff @(posedge mclk_i) begin
    st <= resetn_i ? next_st : '0;
  end
  assign x_o    = st.x;
  assign y_o    = st.y;
  assign ctrl_o = st.ctrl;
endmodule // fbx_seq_model

// ### dv/fbx_function_box_tb_top.sv
// Bench for the function box: loads operands through the sequencer model
// and compares results; assumes outputs settle within the same cycle.
`define FBX_CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module fbx_function_box_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [23:0] x;
    logic [23:0] y;
    logic        cf;
    logic [1:0]  ut;
    logic [4:0]  len;
    logic [23:0] s;
    logic [23:0] d;
    logic [3:0]  bic;
  } fbx_vec_s;
  // ****************************************************************
  // Hand-worked vectors: x, y, carry, type, length, sum, difference_result, nibble
  // ****************************************************************
  localparam fbx_vec_s VEC [8] = '{
    '{24'h00_0005, 24'h00_0003, 1'b1, 2'h0, 5'h18, 24'h00_0009, 24'h00_0001, 4'hC},
    '{24'hAB_CD10, 24'h00_0020, 1'b0, 2'h0, 5'h08, 24'h00_0030, 24'h00_00F0, 4'h0},
    '{24'h00_00FF, 24'h00_0001, 1'b0, 2'h0, 5'h08, 24'h00_0000, 24'h00_00FE, 4'h9},
    '{24'h00_0019, 24'h00_0009, 1'b0, 2'h1, 5'h18, 24'h00_0028, 24'h00_0010, 4'h8},
    '{24'h00_0012, 24'h00_0045, 1'b1, 2'h1, 5'h08, 24'h00_0058, 24'h00_0066, 4'h6},
    '{24'h00_0099, 24'h00_0001, 1'b0, 2'h1, 5'h08, 24'h00_0000, 24'h00_0098, 4'h1},
    '{24'hF1_F2F5, 24'hF0_F3F7, 1'b0, 2'h3, 5'h18, 24'hF1_F6F2, 24'hF0_F8F8, 4'h0},
    '{24'h00_0005, 24'h00_0003, 1'b0, 2'h2, 5'h18, 24'h00_0000, 24'h00_0000, 4'h0}};
  localparam logic [3:0] NIB_RES [8] = '{4'h7, 4'h2, 4'hF, 4'hD, 4'h1, 4'h3, 4'h1, 4'h3};
  localparam logic [11:0] INT_MASK = 12'hE97;
  logic                   mclk_i;
  logic                   resetn_i;
  logic                   ld;
  logic [23:0]            xd;
  logic [23:0]            yd;
  fbx_pkg::fbx_ctrl_s     cd;
  logic [23:0]            xq;
  logic [23:0]            yq;
  fbx_pkg::fbx_ctrl_s     cq;
  logic [3:0]             proc_st;
  logic [3:0]             mem_st;
  logic [3:0]             port_ln;
  fbx_pkg::fbx_nib_req_s  nreq;
  fbx_pkg::fbx_result_s   res;
  fbx_pkg::fbx_cond_s     cnd;
  fbx_pkg::fbx_nib_ans_s  nans;
  int                     errors;
  int                     checks_done;
  int                     cycles;
  fbx_seq_model fbx_seq_model_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .load_i(ld),
    .x_d_i(xd), .y_d_i(yd), .ctrl_d_i(cd), .x_o(xq), .y_o(yq), .ctrl_o(cq));
  fbx_function_box fbx_function_box_inst (.ctrl_i(cq), .x_i(xq), .y_i(yq),
    .proc_status_i(proc_st), .mem_status_i(mem_st), .port_lines_i(port_ln),
    .nib_req_i(nreq), .result_o(res), .cond_o(cnd), .nib_ans_o(nans));
  initial begin
    mclk_i = 1'b0;
  end
  always #5 mclk_i = ~mclk_i;
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded run so a stuck bench still reaches the verdict
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic load(input fbx_vec_s v);
    @(posedge mclk_i);
    ld <= 1'b1;
    xd <= v.x;
    yd <= v.y;
    cd <= '{carry_flag: v.cf, unit_type: v.ut, operand_length: v.len};
    @(posedge mclk_i);
    ld <= 1'b0;
    @(negedge mclk_i);
  endtask
  initial begin
    resetn_i = 1'b0;
    ld = 1'b0;
    xd = '0;
    yd = '0;
    cd = '0;
    proc_st = '0;
    mem_st = '0;
    port_ln = '0;
    nreq = '0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    // Results are read at the falling edge just after the loading edge, with no start or wait
    foreach (VEC[i]) begin
      load(VEC[i]);
      `FBX_CHK(res.sum_result, VEC[i].s, "sum")
      `FBX_CHK(res.difference_result, VEC[i].d, "difference")
      `FBX_CHK(cnd.binary_condition_nibble, VEC[i].bic, "binary nibble")
    end
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk_i);
      {port_ln, mem_st, proc_st} <= 12'h001 << i;
      @(negedge mclk_i);
      `FBX_CHK(cnd.xy_state_nibble[2], INT_MASK[i], "interrupt flag")
      `FBX_CHK(cnd.port_interrupt_nibble, port_ln, "port nibble")
    end
    for (int v = 0; v < 8; v++) begin
      @(posedge mclk_i);
      nreq <= '{operand: 4'hA, literal: 4'h7, variant: v[2:0], source_only: v[0]};
      @(negedge mclk_i);
      `FBX_CHK(nans, {NIB_RES[v], ~v[0], v == 6}, "four-bit answer")
    end
    print_verdict();
  end
endmodule // fbx_function_box_tb_top
